// ---- hdl/post_error_annunciator.sv ----
// start-up progress and error annunciator driving speaker and power led
`timescale 1ns/1ps
// Notes on behaviour
// - A reported recoverable error plays the tone pattern of its type on the speaker.
// - A reported recoverable error also blinks the power led with the pattern of its type.
// - Keyboard prompt ready gives one 0.5 s beep at 932 Hz and no led pattern.
// - While firmware update runs the speaker stays silent.
// - During update the led starts off, then alternates 0.5 s on and 0.5 s off until done.
// - A video error is only taken when no display option rom was found.
// - Video error sounds two 932 Hz beeps of 1 s on 1 s off plus 2.5 s pause, twice, then stops.
// - Video error blinks the led twice 1 s on 1 s off then 2.5 s off, forever.
// - Memory error sounds three 932 Hz beeps 1 s on 1 s off plus 2.5 s pause, forever.
// - Memory error blinks the led three times 1 s on 1 s off then 2.5 s off, forever.
// - Thermal trip sounds eight 1 s tones alternating 2000 Hz high and 1500 Hz low.
// - After the eighth thermal tone ends a shutdown request is raised.
// - Each thermal tone blinks the led twice at 0.25 s phases, sixteen blinks in all.
module post_error_annunciator #(
    parameter int QTR_CYCLES = post_pkg::QTR_CYCLES_DEF
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_kbd_ready,
    input wire logic i_update_active,
    input wire logic i_video_err,
    input wire logic i_video_rom_found,
    input wire logic i_mem_err,
    input wire logic i_thermal_trip,
    output logic o_speaker,
    output logic o_led,
    output logic o_shutdown_req,
    output logic o_active
);
    import post_pkg::*;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // beep on phase within a beeps-then-pause cycle
    function automatic logic beep_on(input pos_t pos, input pos_t beeps);
        pos_t span;
        span = pos_t'(beeps * BEEP_PERIOD_Q);
        beep_on = (pos < span) && ((pos % BEEP_PERIOD_Q) < BEEP_ON_Q);
    endfunction

    // length in quarters of one beeps-then-pause cycle
    function automatic pos_t cycle_len(input pos_t beeps);
        cycle_len = pos_t'(beeps * BEEP_PERIOD_Q + PAUSE_Q);
    endfunction

    // ---------------------------------------------------------------
    // reset release
    // ---------------------------------------------------------------
    logic rst_meta_r;
    logic rst_sync_r;

    // assert at once, release after two clean edges
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // ---------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------
    localparam int QTR_W = $clog2(QTR_CYCLES + 1);
    typedef logic [QTR_W-1:0] qtr_t;
    localparam qtr_t QTR_LAST = qtr_t'(QTR_CYCLES - 1);

    state_e state_r;
    state_e state_nxt;
    logic restart;
    qtr_t qdiv_r;
    logic qtick;
    pos_t pos_r;
    pos_t pos_len;
    logic [1:0] pass_r;
    logic tone_en;
    half_t tone_half;
    logic led_nxt;
    logic led_r;
    logic shutdown_r;

    // ---------------------------------------------------------------
    // quarter second time base
    // ---------------------------------------------------------------
    // restarted with each pattern so the first phase is full length
    always_ff @(posedge i_sys_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            qdiv_r <= '0;
        end else if (restart || qtick) begin
            qdiv_r <= '0;
        end else begin
            qdiv_r <= qdiv_r + qtr_t'(1);
        end
    end

    assign qtick = (qdiv_r == QTR_LAST);

    // ---------------------------------------------------------------
    // pattern selection
    // ---------------------------------------------------------------
    // only thermal cuts in; other requests wait for idle and are lost
    // if they arrive while a pattern runs, since they are pulses; a still-held update is taken once idle is reached
    always_comb begin
        state_nxt = state_r;
        if (i_thermal_trip && state_r != ST_HALT) begin
            state_nxt = ST_THERMAL;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (i_update_active) begin
                        state_nxt = ST_UPDATE;
                    end else if (i_mem_err) begin
                        state_nxt = ST_MEMORY;
                    end else if (i_video_err && !i_video_rom_found) begin
                        state_nxt = ST_VIDEO;
                    end else if (i_kbd_ready) begin
                        state_nxt = ST_PROMPT;
                    end
                end
                ST_PROMPT: begin
                    if (qtick && pos_r == PROMPT_Q - pos_t'(1)) begin
                        state_nxt = ST_IDLE;
                    end
                end
                ST_UPDATE: begin
                    if (!i_update_active) begin
                        state_nxt = ST_IDLE;
                    end
                end
                ST_VIDEO: state_nxt = ST_VIDEO;
                ST_MEMORY: state_nxt = ST_MEMORY;
                ST_THERMAL: begin
                    if (qtick && pos_r == THERM_Q - pos_t'(1)) begin
                        state_nxt = ST_HALT;
                    end
                end
                ST_HALT: state_nxt = ST_HALT;
                default: state_nxt = ST_IDLE;
            endcase
        end
    end

    // a fresh thermal trip restarts its own sequence too
    assign restart = (state_nxt != state_r) || (state_nxt == ST_THERMAL && i_thermal_trip);

    always_ff @(posedge i_sys_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ---------------------------------------------------------------
    // position within the repeating cycle
    // ---------------------------------------------------------------
    always_comb begin
        unique case (state_r)
            ST_UPDATE: pos_len = pos_t'(2 * UPDATE_HALF_Q);
            ST_VIDEO: pos_len = cycle_len(VIDEO_BEEPS);
            ST_MEMORY: pos_len = cycle_len(MEM_BEEPS);
            default: pos_len = THERM_Q;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            pos_r <= '0;
        end else if (restart) begin
            pos_r <= '0;
        end else if (qtick) begin
            if (pos_r == pos_len - pos_t'(1)) begin
                pos_r <= '0;
            end else begin
                pos_r <= pos_r + pos_t'(1);
            end
        end
    end

    // count sounded video passes, saturating so the speaker stays silent after the last
    always_ff @(posedge i_sys_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            pass_r <= '0;
        end else if (restart) begin
            pass_r <= '0;
        end else if (state_r == ST_VIDEO && qtick && pos_r == pos_len - pos_t'(1)
                     && pass_r != VIDEO_PASSES) begin
            pass_r <= pass_r + 2'h1;
        end
    end

    // ---------------------------------------------------------------
    // speaker and led patterns
    // ---------------------------------------------------------------
    always_comb begin
        tone_en = 1'b0;
        tone_half = HALF_MID;
        led_nxt = 1'b0;
        unique case (state_r)
            ST_PROMPT: tone_en = 1'b1;
            ST_UPDATE: begin
                tone_en = 1'b0;
                led_nxt = (pos_r >= UPDATE_HALF_Q);
            end
            ST_VIDEO: begin
                tone_en = (pass_r != VIDEO_PASSES) && beep_on(pos_r, VIDEO_BEEPS);
                led_nxt = beep_on(pos_r, VIDEO_BEEPS);
            end
            ST_MEMORY: begin
                tone_en = beep_on(pos_r, MEM_BEEPS);
                led_nxt = beep_on(pos_r, MEM_BEEPS);
            end
            ST_THERMAL: begin
                tone_en = 1'b1;
                tone_half = pos_r[2] ? HALF_LOW : HALF_HIGH;
                led_nxt = ~pos_r[0];
            end
            default: begin
                tone_en = 1'b0;
            end
        endcase
        if (restart) begin
            tone_en = 1'b0; // pattern boundary, one silent cycle
            led_nxt = 1'b0;
        end
    end

    // led and shutdown come from flops
    always_ff @(posedge i_sys_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            led_r <= 1'b0;
            shutdown_r <= 1'b0;
        end else begin
            led_r <= led_nxt;
            shutdown_r <= (state_nxt == ST_HALT);
        end
    end

    tone_div u_tone (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(rst_sync_r),
        .i_en(tone_en),
        .i_half(tone_half),
        .o_wave(o_speaker)
    );

    assign o_led = led_r;
    assign o_shutdown_req = shutdown_r;
    assign o_active = (state_r != ST_IDLE);
endmodule

// ---- hdl/post_pkg.sv ----
// constants shared by the start-up annunciator and its tone divider
package post_pkg;
    // ---------------------------------------------------------------
    // clock and tone timing
    // ---------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int TONE_MID_HZ = 932;
    localparam int TONE_HIGH_HZ = 2000;
    localparam int TONE_LOW_HZ = 1500;
    localparam int HALF_W = 16;
    typedef logic [HALF_W-1:0] half_t;
    // half period in cycles, rounded down so the tone is never flat
    localparam half_t HALF_MID = half_t'(CLK_HZ / (2 * TONE_MID_HZ));
    localparam half_t HALF_HIGH = half_t'(CLK_HZ / (2 * TONE_HIGH_HZ));
    localparam half_t HALF_LOW = half_t'(CLK_HZ / (2 * TONE_LOW_HZ));

    // ---------------------------------------------------------------
    // pattern time base: everything is a whole number of quarter seconds
    // ---------------------------------------------------------------
    localparam int QTR_MS = 250;
    localparam int QTR_CYCLES_DEF = (CLK_HZ / 1000) * QTR_MS;
    localparam int PROMPT_MS = 500;
    localparam int UPDATE_HALF_MS = 500;
    localparam int BEEP_ON_MS = 1000;
    localparam int PAUSE_MS = 2500;
    localparam int POS_W = 6;
    typedef logic [POS_W-1:0] pos_t;
    localparam pos_t PROMPT_Q = pos_t'(PROMPT_MS / QTR_MS);
    localparam pos_t UPDATE_HALF_Q = pos_t'(UPDATE_HALF_MS / QTR_MS);
    localparam pos_t BEEP_ON_Q = pos_t'(BEEP_ON_MS / QTR_MS);
    localparam pos_t BEEP_PERIOD_Q = pos_t'(2 * (BEEP_ON_MS / QTR_MS));
    localparam pos_t PAUSE_Q = pos_t'(PAUSE_MS / QTR_MS);
    localparam pos_t VIDEO_BEEPS = 6'h02;
    localparam pos_t MEM_BEEPS = 6'h03;
    localparam pos_t THERM_BEEPS = 6'h08;
    localparam pos_t THERM_Q = pos_t'(8 * (BEEP_ON_MS / QTR_MS));
    localparam logic [1:0] VIDEO_PASSES = 2'h2;

    // ---------------------------------------------------------------
    // pattern states
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_PROMPT = 3'h1,
        ST_UPDATE = 3'h2,
        ST_VIDEO = 3'h3,
        ST_MEMORY = 3'h4,
        ST_THERMAL = 3'h5,
        ST_HALT = 3'h6
    } state_e;
endpackage

// ---- hdl/tone_div.sv ----
// square wave tone generator dividing the system clock
`timescale 1ns/1ps
module tone_div (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_en,
    input wire post_pkg::half_t i_half,
    output logic o_wave
);
    import post_pkg::*;

    half_t cnt_r;
    logic wave_r;

    // ---------------------------------------------------------------
    // half period counter
    // ---------------------------------------------------------------
    // >= rather than == so a lower half period mid-tone cannot overrun
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_r <= '0;
            wave_r <= 1'b0;
        end else if (!i_en) begin
            cnt_r <= '0;
            wave_r <= 1'b0; // silent line rests low
        end else if (cnt_r >= i_half - half_t'(1)) begin
            cnt_r <= '0;
            wave_r <= ~wave_r;
        end else begin
            cnt_r <= cnt_r + half_t'(1);
        end
    end

    assign o_wave = wave_r;
endmodule

// ---- verification/post_error_annunciator_asserts.sv ----
// assertions on the annunciator ports
`timescale 1ns/1ps
module post_error_annunciator_asserts #(
    parameter int QTR_CYCLES = 40
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_kbd_ready,
    input wire logic i_update_active,
    input wire logic i_video_err,
    input wire logic i_video_rom_found,
    input wire logic i_mem_err,
    input wire logic i_thermal_trip,
    input wire logic o_speaker,
    input wire logic o_led,
    input wire logic o_shutdown_req,
    input wire logic o_active
);
    // ---------------------------------------------------------------
    // helper: length of the current led on run
    // ---------------------------------------------------------------
    int led_run;
    logic busy_in;
    assign busy_in = i_update_active | i_mem_err | i_video_err | i_thermal_trip;
    // counter instead of a long repetition keeps the tools fast
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            led_run <= 0;
        end else begin
            led_run <= o_led ? led_run + 1 : 0;
        end
    end
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);
    a_shutdown_held: assert property (o_shutdown_req |=> o_shutdown_req)
        else $error("shutdown request dropped");
    a_halt_quiet: assert property (o_shutdown_req |=> !o_led && !o_speaker)
        else $error("outputs active after shutdown");
    a_idle_dark: assert property (!o_active [*3] |-> !o_led && !o_speaker)
        else $error("output on while idle");
    a_thermal_taken: assert property (i_thermal_trip && !o_shutdown_req |=> o_active)
        else $error("thermal trip not taken");
    a_rom_refused: assert property (i_video_err && i_video_rom_found && !o_active && !i_kbd_ready
        && !i_update_active && !i_mem_err && !i_thermal_trip |=> !o_active)
        else $error("video error taken with rom present");
    a_mem_taken: assert property (i_mem_err && !o_active && !i_update_active |=> o_active)
        else $error("memory error not taken");
    a_prompt_dark: assert property (i_kbd_ready && !o_active && !busy_in
        |=> (o_active && !o_led) [*8])
        else $error("led lit during prompt");
    a_led_width: assert property (led_run <= 4 * QTR_CYCLES)
        else $error("led on run too long");
    c_shutdown: cover property ($rose(o_shutdown_req));
    c_led_off: cover property ($fell(o_led));
    c_mem: cover property (i_mem_err && !o_active);
endmodule
bind post_error_annunciator post_error_annunciator_asserts #(.QTR_CYCLES(QTR_CYCLES)) i_asserts (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_kbd_ready(i_kbd_ready),
    .i_update_active(i_update_active), .i_video_err(i_video_err),
    .i_video_rom_found(i_video_rom_found), .i_mem_err(i_mem_err),
    .i_thermal_trip(i_thermal_trip), .o_speaker(o_speaker), .o_led(o_led),
    .o_shutdown_req(o_shutdown_req), .o_active(o_active));

// ---- verification/panel_model.sv ----
// board speaker and power led load that reports each led on run
`timescale 1ns/1ps
module panel_model (
    input wire logic i_sys_clk,
    input wire logic i_speaker,
    input wire logic i_led,
    output int o_len,
    output int o_tones,
    output logic o_done
);
    int run = 0;
    logic spk_d = 1'b0;
    initial o_tones = 0;
    initial o_done = 1'b0;
    // run length is handed over one cycle after the led goes dark
    always @(posedge i_sys_clk) begin
        o_done <= 1'b0;
        spk_d <= i_speaker;
        if (i_speaker !== spk_d) begin
            o_tones <= o_tones + 1;
        end
        if (i_led === 1'b1) begin
            run <= run + 1;
        end else if (run != 0) begin
            o_len <= run;
            o_done <= 1'b1;
            run <= 0;
        end
    end
endmodule

// ---- verification/test_post_error_annunciator.sv ----
// self-checking bench for the annunciator
`timescale 1ns/1ps
module test_post_error_annunciator;
    localparam int Q = 40;
    logic clk = 1'b0, rst_b = 1'b0, kbd = 1'b0, upd = 1'b0, vid = 1'b0;
    logic rom = 1'b0, mem = 1'b0, therm = 1'b0;
    logic spk, led, shut, active, done;
    int len;
    int bad_count = 0;
    int n_compared = 0;
    int exp_q[$];
    // second copy on a slow time base so a real tone edge fits in the run
    localparam int Q_TONE = 7000;
    logic rst_t_b = 1'b0, therm_t = 1'b0, tone_done = 1'b0;
    logic spk_t, led_t;
    int tones_t;
    int tones_before = 0;
    post_error_annunciator #(.QTR_CYCLES(Q)) i_post_error_annunciator (
        .i_sys_clk(clk), .i_rst_b(rst_b), .i_kbd_ready(kbd), .i_update_active(upd),
        .i_video_err(vid), .i_video_rom_found(rom), .i_mem_err(mem), .i_thermal_trip(therm),
        .o_speaker(spk), .o_led(led), .o_shutdown_req(shut), .o_active(active));
    panel_model i_panel_model (.i_sys_clk(clk), .i_speaker(spk), .i_led(led), .o_len(len),
        .o_tones(), .o_done(done));
    // own reset, so the mid-run resets of the main copy leave this one alone
    post_error_annunciator #(.QTR_CYCLES(Q_TONE)) i_post_error_annunciator_tone (
        .i_sys_clk(clk), .i_rst_b(rst_t_b), .i_kbd_ready(kbd), .i_update_active(upd),
        .i_video_err(vid), .i_video_rom_found(rom), .i_mem_err(mem), .i_thermal_trip(therm_t),
        .o_speaker(spk_t), .o_led(led_t), .o_shutdown_req(), .o_active());
    panel_model i_panel_model_tone (.i_sys_clk(clk), .i_speaker(spk_t), .i_led(led_t),
        .o_len(), .o_tones(tones_t), .o_done());
    // 100 MHz clock
    initial begin
        forever #5 clk = ~clk;
    end
    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic check_bit(string what, logic exp, logic got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic check_len(int exp, int got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value led run expected %0d seen %0d", exp, got);
        end
    endtask
    task automatic check_tones(int exp, int got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value speaker edges expected %0d seen %0d", exp, got);
        end
    endtask
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic wait_q(int n);
        repeat (n) @(negedge clk);
    endtask
    // random spacing moves every request to a new phase of the time base
    task automatic pulse(ref logic sig);
        repeat ($urandom_range(8, 1)) @(negedge clk);
        sig = 1'b1;
        @(negedge clk);
        sig = 1'b0;
    endtask
    task automatic expect_runs(int count, int width);
        repeat (count) exp_q.push_back(width);
    endtask
    // a led run left unseen at the limit counts as a mismatch
    task automatic drain(int limit);
        for (int i = 0; i < limit && exp_q.size() != 0; i++) @(negedge clk);
        check_len(0, exp_q.size());
        exp_q.delete();
    endtask
    task automatic do_reset();
        rst_b = 1'b0;
        wait_q(12);
        rst_b = 1'b1;
        wait_q(3);
    endtask
    // watcher: each led run is matched against the oldest note, or against 0 when no note is left
    always @(posedge clk) begin
        if (done === 1'b1) begin
            if (exp_q.size() == 0) begin
                check_len(0, len);
            end else begin
                check_len(exp_q.pop_front(), len);
            end
        end
    end
    // high thermal tone on the slow copy: silent for one half period, then one rise
    // the trip lands before any main-copy pulse can, so nothing else is taken first
    initial begin
        wait_q(12);
        rst_t_b = 1'b1;
        wait_q(3);
        therm_t = 1'b1;
        @(negedge clk);
        therm_t = 1'b0;
        tones_before = tones_t;
        wait_q(int'(post_pkg::HALF_HIGH) - 2);
        check_bit("tone speaker", 1'b0, spk_t);
        check_tones(0, tones_t - tones_before);
        wait_q(4);
        check_bit("tone speaker", 1'b1, spk_t);
        check_tones(1, tones_t - tones_before);
        tone_done = 1'b1;
    end
    // watchdog well beyond the expected run length
    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        print_verdict();
    end
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    initial begin
        void'($urandom(32'he99c2ba6));
        do_reset();
        pulse(kbd);
        check_bit("active", 1'b1, active);
        wait_q(2 * Q + 4);
        check_bit("active", 1'b0, active);
        rom = 1'b1;
        pulse(vid);
        wait_q(2);
        check_bit("active", 1'b0, active);
        rom = 1'b0;
        expect_runs(6, 4 * Q);
        pulse(mem);
        drain(80 * Q);
        wait_q(5 * Q);
        expect_runs(16, Q);
        pulse(therm);
        wait_q(32 * Q - 4);
        check_bit("shutdown", 1'b0, shut);
        wait_q(6);
        check_bit("shutdown", 1'b1, shut);
        drain(Q);
        pulse(mem);
        wait_q(10 * Q);
        check_bit("active", 1'b1, active);
        do_reset();
        expect_runs(4, 4 * Q);
        pulse(vid);
        drain(60 * Q);
        do_reset();
        expect_runs(3, 2 * Q);
        upd = 1'b1;
        drain(16 * Q);
        check_bit("speaker", 1'b0, spk);
        upd = 1'b0;
        wait_q(4);
        check_bit("active", 1'b0, active);
        wait (tone_done);
        print_verdict();
    end
endmodule
